/* include/xo_pll_pkg.sv */
/*
  Constants for the margining and PLL wait register bank: register indexes,
  field positions, reset values, wait times and their cycle counts.
  Assumes a 125 MHz system clock; byte address of a register is four times its index.
*/
package xo_pll_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ = 125;

  // ----------------------------------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_STEP8_LOW    = 10'h067;
  localparam logic [9:0] IDX_SW_OFS_HIGH  = 10'h068;
  localparam logic [9:0] IDX_SW_OFS_LOW   = 10'h069;
  localparam logic [9:0] IDX_PUMP_CTRL    = 10'h075;
  localparam logic [9:0] IDX_FILTER_CTRL  = 10'h076;
  localparam logic [9:0] IDX_CAL_WAIT     = 10'h077;
  localparam logic [9:0] IDX_MARGIN_MODE  = 10'h07a;
  localparam logic [9:0] IDX_CAL_CONTROL  = 10'h07b;
  localparam logic [9:0] IDX_CAL_STATUS   = 10'h07c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned POS_STRETCH     = 7;
  localparam int unsigned POS_CLSD_WAIT   = 2;
  localparam int unsigned POS_VCO_WAIT    = 0;
  localparam int unsigned POS_CAL_START   = 0;
  localparam int unsigned POS_STAT_BUSY   = 0;
  localparam int unsigned POS_STAT_DONE   = 1;
  localparam int unsigned POS_STAT_STEP   = 4;
  localparam logic [7:0] RST_STEP8_LOW    = 8'h9e;
  localparam logic [1:0] RST_SW_OFS_HIGH  = 2'h0;
  localparam logic [7:0] RST_SW_OFS_LOW   = 8'h00;
  localparam logic       RST_STRETCH      = 1'b0;
  localparam logic [2:0] RST_FILTER       = 3'h3;
  localparam logic [1:0] RST_CLSD_WAIT    = 2'h0;
  localparam logic [1:0] RST_VCO_WAIT     = 2'h1;
  localparam logic [1:0] RST_MARGIN_MODE  = 2'h0;

  // Loop filter codes that are not reserved
  localparam logic [2:0] FILTER_2ND_ORDER = 3'h3;
  localparam logic [2:0] FILTER_3RD_ORDER = 3'h7;

  // Margining modes
  localparam logic [1:0] MODE_OFF         = 2'h0;
  localparam logic [1:0] MODE_PIN_STEP    = 2'h1;
  localparam logic [1:0] MODE_SOFTWARE    = 2'h2;

  // Stored step offsets 1..7 and upper bits of step 8
  localparam logic [9:0] STEP_OFS [0:6] = '{10'h0de, 10'h118, 10'h14b, 10'h186,
                                           10'h1be, 10'h1fe, 10'h247};
  localparam logic [1:0] STEP8_HIGH       = 2'h2;

  // ----------------------------------------------------------------
  // Phase detector pump width
  // ----------------------------------------------------------------
  localparam logic [9:0] PUMP_NARROW_PS   = 10'd200;
  localparam logic [9:0] PUMP_WIDE_PS     = 10'd600;

  // ----------------------------------------------------------------
  // Wait times and cycle counts (least times, exact at 125 MHz)
  // ----------------------------------------------------------------
  localparam int unsigned CLSD_T0_US      = 30;
  localparam int unsigned CLSD_T1_US      = 300;
  localparam int unsigned CLSD_T2_MS      = 30;
  localparam int unsigned CLSD_T3_MS      = 300;
  localparam int unsigned VCO_T0_US       = 20;
  localparam int unsigned VCO_T1_US       = 400;
  localparam int unsigned VCO_T2_US       = 8000;
  localparam int unsigned VCO_T3_US       = 200000;
  localparam int unsigned CLSD_CYC0       = CLSD_T0_US * CLK_FREQ_MHZ;
  localparam int unsigned CLSD_CYC1       = CLSD_T1_US * CLK_FREQ_MHZ;
  localparam int unsigned CLSD_CYC2       = CLSD_T2_MS * 1000 * CLK_FREQ_MHZ;
  localparam int unsigned CLSD_CYC3       = CLSD_T3_MS * 1000 * CLK_FREQ_MHZ;
  localparam int unsigned VCO_CYC0        = VCO_T0_US * CLK_FREQ_MHZ;
  localparam int unsigned VCO_CYC1        = VCO_T1_US * CLK_FREQ_MHZ;
  localparam int unsigned VCO_CYC2        = VCO_T2_US * CLK_FREQ_MHZ;
  localparam int unsigned VCO_CYC3        = VCO_T3_US * CLK_FREQ_MHZ;

  // ----------------------------------------------------------------
  // Bus responses and calibration states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_VCO  = 2'b01,
    CAL_CLSD = 2'b11,
    CAL_DONE = 2'b10
  } cal_state_type;

endpackage : xo_pll_pkg

/* src/wait_timer.sv */
/*
  Down-counting wait timer: a start pulse loads a cycle count, the timer stays
  busy for exactly that many cycles and gives a one-cycle expire in the last of them.
  Assumes load_cycles is at least one when start is raised.
*/
`timescale 1ns/1ps
module wait_timer (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [31:0] load_cycles,
  output logic             busy,
  output logic             expire
);

  logic        busy_q;
  logic        busy_d;
  logic [31:0] count_q;
  logic [31:0] count_d;

  assign busy   = busy_q;
  assign expire = busy_q && (count_q == 32'h0000_0000);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Next count: load on start, count down while busy
  always_comb begin
    busy_d  = busy_q;
    count_d = count_q;
    if (start) begin
      busy_d  = 1'b1;
      count_d = load_cycles - 32'h0000_0001;
    end else if (expire) begin
      busy_d  = 1'b0;
    end else if (busy_q) begin
      count_d = count_q - 32'h0000_0001;
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q  <= 1'b0;
      count_q <= 32'h0000_0000;
    end else begin
      busy_q  <= busy_d;
      count_q <= count_d;
    end
  end

endmodule : wait_timer

/* src/xo_margin_pll_wait_regs.sv */
/*
  Margining offset and PLL control register bank with calibration wait sequencer,
  reached over AXI4-Lite. Each register is one aligned word, data in bits 7:0.
  Assumes a single 125 MHz clock, synchronous inputs and an AXI4-Lite master
  with at most one read and one write outstanding.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module xo_margin_pll_wait_regs
  import xo_pll_pkg::*;
#(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned CLSD_CYC_0 = xo_pll_pkg::CLSD_CYC0,
  parameter int unsigned CLSD_CYC_1 = xo_pll_pkg::CLSD_CYC1,
  parameter int unsigned CLSD_CYC_2 = xo_pll_pkg::CLSD_CYC2,
  parameter int unsigned CLSD_CYC_3 = xo_pll_pkg::CLSD_CYC3,
  parameter int unsigned VCO_CYC_0  = xo_pll_pkg::VCO_CYC0,
  parameter int unsigned VCO_CYC_1  = xo_pll_pkg::VCO_CYC1,
  parameter int unsigned VCO_CYC_2  = xo_pll_pkg::VCO_CYC2,
  parameter int unsigned VCO_CYC_3  = xo_pll_pkg::VCO_CYC3
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              margin_step_select_pin,
  output logic [9:0]             margin_offset,
  output logic                   pump_stretch,
  output logic [9:0]             pump_width_ps,
  output logic [2:0]             loop_filter_order_select,
  output logic [1:0]             closed_loop_wait_select,
  output logic [1:0]             vco_settle_wait_select,
  output logic                   cal_busy,
  output logic                   cal_done
);

  import xo_pll_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 12 and 32");
  end
  if (CLSD_CYC_0 == 0 || CLSD_CYC_1 == 0 || CLSD_CYC_2 == 0 || CLSD_CYC_3 == 0 ||
      VCO_CYC_0 == 0 || VCO_CYC_1 == 0 || VCO_CYC_2 == 0 || VCO_CYC_3 == 0) begin : g_bad_cyc
    $error("wait cycle counts must be at least one");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Word index of a byte address
  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[11:2];
  endfunction : reg_index

  // Cycle count for a closed-loop or VCO wait code
  function automatic logic [31:0] wait_cycles(input logic vco, input logic [1:0] code);
    case ({vco, code})
      3'b000:  wait_cycles = 32'(CLSD_CYC_0);
      3'b001:  wait_cycles = 32'(CLSD_CYC_1);
      3'b010:  wait_cycles = 32'(CLSD_CYC_2);
      3'b011:  wait_cycles = 32'(CLSD_CYC_3);
      3'b100:  wait_cycles = 32'(VCO_CYC_0);
      3'b101:  wait_cycles = 32'(VCO_CYC_1);
      3'b110:  wait_cycles = 32'(VCO_CYC_2);
      default: wait_cycles = 32'(VCO_CYC_3);
    endcase
  endfunction : wait_cycles

  // ----------------------------------------------------------------
  // Bus and register state
  // ----------------------------------------------------------------
  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [7:0]        wbyte_q, wbyte_d;
  logic              wlane_q, wlane_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [7:0]        step8_low_q, step8_low_d;
  logic [1:0]        sw_high_q, sw_high_d;
  logic [7:0]        sw_low_q, sw_low_d;
  logic              stretch_q, stretch_d;
  logic [2:0]        filter_q, filter_d;
  logic [1:0]        clsd_q, clsd_d, vco_q, vco_d;
  logic [1:0]        mode_q, mode_d;
  logic              start_q, start_d;
  logic              aw_take, w_take, ar_take, do_write;
  logic [ADDR_W-1:0] cur_addr;
  logic [7:0]        cur_byte;
  logic              cur_lane;
  logic [7:0]        rbyte;
  logic              rhit;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Calibration status, driven further down
  cal_state_type     cal_q, cal_d;
  logic [2:0]        step_q, step_d;

  // Next bus and register values
  always_comb begin
    aw_take     = s_axi_awvalid && s_axi_awready;
    w_take      = s_axi_wvalid && s_axi_wready;
    ar_take     = s_axi_arvalid && s_axi_arready;
    cur_addr    = aw_take ? s_axi_awaddr : waddr_q;
    cur_byte    = w_take ? s_axi_wdata[7:0] : wbyte_q;
    cur_lane    = w_take ? s_axi_wstrb[0] : wlane_q;
    do_write    = (aw_hold_q || aw_take) && (w_hold_q || w_take);
    aw_hold_d   = (aw_hold_q || aw_take) && !do_write;
    w_hold_d    = (w_hold_q || w_take) && !do_write;
    waddr_d     = cur_addr;
    wbyte_d     = cur_byte;
    wlane_d     = cur_lane;
    bvalid_d    = bvalid_q && !s_axi_bready;
    bresp_d     = bresp_q;
    step8_low_d = step8_low_q;
    sw_high_d   = sw_high_q;
    sw_low_d    = sw_low_q;
    stretch_d   = stretch_q;
    filter_d    = filter_q;
    clsd_d      = clsd_q;
    vco_d       = vco_q;
    mode_d      = mode_q;
    start_d     = 1'b0;
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      case (reg_index(cur_addr))
        IDX_STEP8_LOW:   if (cur_lane) step8_low_d = cur_byte;
        IDX_SW_OFS_HIGH: if (cur_lane) sw_high_d = cur_byte[1:0];
        IDX_SW_OFS_LOW:  if (cur_lane) sw_low_d = cur_byte;
        IDX_PUMP_CTRL:   if (cur_lane) stretch_d = cur_byte[POS_STRETCH];
        IDX_FILTER_CTRL: begin
          if (cur_lane && (cur_byte[2:0] == FILTER_2ND_ORDER || cur_byte[2:0] == FILTER_3RD_ORDER)) begin
            filter_d = cur_byte[2:0];
          end
        end
        IDX_CAL_WAIT: begin
          if (cur_lane) begin
            clsd_d = cur_byte[POS_CLSD_WAIT +: 2];
            vco_d  = cur_byte[POS_VCO_WAIT +: 2];
          end
        end
        IDX_MARGIN_MODE: if (cur_lane) mode_d = cur_byte[1:0];
        IDX_CAL_CONTROL: start_d = cur_lane && cur_byte[POS_CAL_START];
        IDX_CAL_STATUS:  bresp_d = RESP_OKAY;
        default:         bresp_d = RESP_SLVERR;
      endcase
    end
    rhit  = 1'b1;
    rbyte = 8'h00;
    case (reg_index(s_axi_araddr))
      IDX_STEP8_LOW:   rbyte = step8_low_q;
      IDX_SW_OFS_HIGH: rbyte = {6'h00, sw_high_q};
      IDX_SW_OFS_LOW:  rbyte = sw_low_q;
      IDX_PUMP_CTRL:   rbyte = {stretch_q, 7'h00};
      IDX_FILTER_CTRL: rbyte = {5'h00, filter_q};
      IDX_CAL_WAIT:    rbyte = {4'h0, clsd_q, vco_q};
      IDX_MARGIN_MODE: rbyte = {6'h00, mode_q};
      IDX_CAL_CONTROL: rbyte = 8'h00;
      IDX_CAL_STATUS:  rbyte = {1'b0, step_q, 2'b00, cal_q == CAL_DONE, cal_q == CAL_VCO || cal_q == CAL_CLSD};
      default:         rhit  = 1'b0;
    endcase
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h00_0000, rbyte};
      rresp_d  = rhit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Bus and register flip-flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      waddr_q     <= '0;
      wbyte_q     <= 8'h00;
      wlane_q     <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      rdata_q     <= 32'h0000_0000;
      step8_low_q <= RST_STEP8_LOW;
      sw_high_q   <= RST_SW_OFS_HIGH;
      sw_low_q    <= RST_SW_OFS_LOW;
      stretch_q   <= RST_STRETCH;
      filter_q    <= RST_FILTER;
      clsd_q      <= RST_CLSD_WAIT;
      vco_q       <= RST_VCO_WAIT;
      mode_q      <= RST_MARGIN_MODE;
      start_q     <= 1'b0;
    end else begin
      aw_hold_q   <= aw_hold_d;
      w_hold_q    <= w_hold_d;
      waddr_q     <= waddr_d;
      wbyte_q     <= wbyte_d;
      wlane_q     <= wlane_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
      step8_low_q <= step8_low_d;
      sw_high_q   <= sw_high_d;
      sw_low_q    <= sw_low_d;
      stretch_q   <= stretch_d;
      filter_q    <= filter_d;
      clsd_q      <= clsd_d;
      vco_q       <= vco_d;
      mode_q      <= mode_d;
      start_q     <= start_d;
    end
  end

  assign pump_stretch             = stretch_q;
  assign loop_filter_order_select = filter_q;
  assign closed_loop_wait_select  = clsd_q;
  assign vco_settle_wait_select   = vco_q;

  // ----------------------------------------------------------------
  // Margining offset, pump width and calibration sequence
  // ----------------------------------------------------------------
  logic       pin_q, pin_d;
  logic [9:0] offset_q, offset_d;
  logic [9:0] pwidth_q, pwidth_d;
  logic       tmr_start, tmr_expire;
  logic [31:0] tmr_load;

  assign margin_offset = offset_q;
  assign pump_width_ps = pwidth_q;
  assign cal_busy      = (cal_q == CAL_VCO) || (cal_q == CAL_CLSD);
  assign cal_done      = (cal_q == CAL_DONE);

  // Next offset, pump width and sequencer state
  always_comb begin
    pin_d  = margin_step_select_pin;
    step_d = step_q;
    if (margin_step_select_pin && !pin_q && mode_q == MODE_PIN_STEP) begin
      step_d = step_q + 3'h1;
    end
    case (mode_q)
      MODE_PIN_STEP: offset_d = (step_q == 3'h7) ? {STEP8_HIGH, step8_low_q} : STEP_OFS[step_q];
      MODE_SOFTWARE: offset_d = {sw_high_q, sw_low_q};
      default:       offset_d = 10'h000;
    endcase
    pwidth_d  = stretch_q ? PUMP_WIDE_PS : PUMP_NARROW_PS;
    cal_d     = cal_q;
    tmr_start = 1'b0;
    tmr_load  = wait_cycles(1'b1, vco_q);
    case (cal_q)
      CAL_IDLE, CAL_DONE: begin
        if (start_q) begin
          tmr_start = 1'b1;
          cal_d     = CAL_VCO;
        end
      end
      CAL_VCO: begin
        if (tmr_expire) begin
          tmr_start = 1'b1;
          tmr_load  = wait_cycles(1'b0, clsd_q);
          cal_d     = CAL_CLSD;
        end
      end
      CAL_CLSD: if (tmr_expire) cal_d = CAL_DONE;
      default:  cal_d = CAL_IDLE;
    endcase
  end

  // Offset and sequencer flip-flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_q    <= 1'b0;
      step_q   <= 3'h0;
      offset_q <= 10'h000;
      pwidth_q <= PUMP_NARROW_PS;
      cal_q    <= CAL_IDLE;
    end else begin
      pin_q    <= pin_d;
      step_q   <= step_d;
      offset_q <= offset_d;
      pwidth_q <= pwidth_d;
      cal_q    <= cal_d;
    end
  end

  // Shared wait counter
  wait_timer u_wait_timer (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .start       (tmr_start),
    .load_cycles (tmr_load),
    .busy        (),
    .expire      (tmr_expire)
  );

endmodule : xo_margin_pll_wait_regs

/* bench/xo_margin_pll_wait_regs_asserts.sv */
/*
  Checker for the margining and PLL wait register bank outputs.
  Assumes the bound instance hands on its shortest and longest wait counts.
*/
`timescale 1ns/1ps
module xo_margin_pll_wait_regs_asserts #(
  parameter int unsigned VCO_CYC_0  = 2,
  parameter int unsigned VCO_CYC_3  = 8,
  parameter int unsigned CLSD_CYC_0 = 3,
  parameter int unsigned CLSD_CYC_3 = 9
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       pump_stretch,
  input wire logic [9:0] pump_width_ps,
  input wire logic [2:0] loop_filter_order_select,
  input wire logic [1:0] closed_loop_wait_select,
  input wire logic [1:0] vco_settle_wait_select,
  input wire logic       cal_busy,
  input wire logic       cal_done
);
  localparam int unsigned MIN_BUSY = VCO_CYC_0 + CLSD_CYC_0;
  localparam int unsigned MAX_BUSY = VCO_CYC_3 + CLSD_CYC_3;
  int unsigned busy_len_q;
  int unsigned busy_len_d;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Counts busy cycles of the running calibration
  always_comb busy_len_d = cal_busy ? busy_len_q + 1 : 0;
  always_ff @(posedge clk_sys) busy_len_q <= sys_rst ? 0 : busy_len_d;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_PUMP_WIDE:
    assert property (pump_stretch && $past(pump_stretch) |-> pump_width_ps == 10'h258)
    else $error("pump width not wide while stretched");
  AST_PUMP_NARROW:
    assert property (!pump_stretch && !$past(pump_stretch) |-> pump_width_ps == 10'h0c8)
    else $error("pump width not narrow while unstretched");
  AST_FILTER_CODE:
    assert property (loop_filter_order_select == 3'h3 || loop_filter_order_select == 3'h7)
    else $error("loop filter holds a reserved code");
  AST_RESET_FIELDS:
    assert property ($past(sys_rst) |-> vco_settle_wait_select == 2'h1 && closed_loop_wait_select == 2'h0)
    else $error("wait fields wrong after reset");
  AST_BUSY_DONE_EXCL:
    assert property (!(cal_busy && cal_done))
    else $error("busy and done high together");
  AST_BUSY_SHORTEST:
    assert property ($fell(cal_busy) |-> busy_len_q >= MIN_BUSY)
    else $error("calibration wait ended too early");
  AST_BUSY_LONGEST:
    assert property (cal_busy |-> busy_len_q < MAX_BUSY)
    else $error("calibration wait overran");
  AST_DONE_AFTER_BUSY:
    assert property ($rose(cal_done) |-> $past(cal_busy) && !cal_busy)
    else $error("done raised without a finished wait");

  // Main scenarios reached
  COV_DONE: cover property ($rose(cal_done));
  COV_STRETCH: cover property ($rose(pump_stretch));
  COV_THIRD_ORDER: cover property (loop_filter_order_select == 3'h7);
endmodule : xo_margin_pll_wait_regs_asserts

bind xo_margin_pll_wait_regs xo_margin_pll_wait_regs_asserts #(
  .VCO_CYC_0(VCO_CYC_0), .VCO_CYC_3(VCO_CYC_3), .CLSD_CYC_0(CLSD_CYC_0), .CLSD_CYC_3(CLSD_CYC_3)
) u_asserts (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .pump_stretch(pump_stretch), .pump_width_ps(pump_width_ps),
  .loop_filter_order_select(loop_filter_order_select), .closed_loop_wait_select(closed_loop_wait_select),
  .vco_settle_wait_select(vco_settle_wait_select), .cal_busy(cal_busy), .cal_done(cal_done)
);

/* bench/xo_margin_pll_wait_regs_test.sv */
/*
  Self-checking bench for the register bank, driven over AXI4-Lite.
  Assumes short wait counts set by parameter and the byte address 4 * index.
*/
`timescale 1ns/1ps
module xo_margin_pll_wait_regs_test;
  import xo_pll_pkg::*;
  localparam int unsigned VC [4] = '{2, 4, 6, 8};
  localparam int unsigned CC [4] = '{3, 5, 7, 9};
  localparam logic [9:0] RIDX [6] = '{IDX_STEP8_LOW, IDX_SW_OFS_HIGH, IDX_SW_OFS_LOW,
                                      IDX_PUMP_CTRL, IDX_FILTER_CTRL, IDX_CAL_WAIT};
  localparam logic [7:0] RRST [6] = '{8'h9e, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
  localparam logic [7:0] RNEW [4] = '{8'h5a, 8'h03, 8'ha5, 8'h80};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, closed_loop_wait_select, vco_settle_wait_select, r;
  logic margin_step_select_pin = 1'b0;
  logic [9:0] margin_offset, pump_width_ps;
  logic [2:0] loop_filter_order_select;
  logic pump_stretch, cal_busy, cal_done;
  int err_count = 0, comparisons = 0, cycles = 0, n;

  xo_margin_pll_wait_regs #(
    .CLSD_CYC_0(CC[0]), .CLSD_CYC_1(CC[1]), .CLSD_CYC_2(CC[2]), .CLSD_CYC_3(CC[3]),
    .VCO_CYC_0(VC[0]), .VCO_CYC_1(VC[1]), .VCO_CYC_2(VC[2]), .VCO_CYC_3(VC[3])
  ) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .margin_step_select_pin(margin_step_select_pin), .margin_offset(margin_offset),
    .pump_stretch(pump_stretch), .pump_width_ps(pump_width_ps),
    .loop_filter_order_select(loop_filter_order_select), .closed_loop_wait_select(closed_loop_wait_select),
    .vco_settle_wait_select(vco_settle_wait_select), .cal_busy(cal_busy), .cal_done(cal_done)
  );

  // Clock at 125 MHz
  always #4 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
    bit aw_ok = 1'b0, w_ok = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] exp_resp);
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, exp});
    chk({30'h0, s_axi_rresp}, {30'h0, exp_resp});
  endtask : rd_chk

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : wait_clk

  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(RIDX[i], RRST[i], RESP_OKAY);
    chk({17'h0, pump_width_ps, loop_filter_order_select, vco_settle_wait_select}, {17'h0, 10'h0c8, 3'h3, 2'h1});
    rd_chk(10'h000, 8'h00, RESP_SLVERR);
    wr(10'h000, 8'h11, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++) wr(RIDX[i], RNEW[i], r);
    for (int i = 0; i < 4; i++) rd_chk(RIDX[i], RNEW[i], RESP_OKAY);
    wait_clk(2);
    chk({21'h0, pump_stretch, pump_width_ps}, {21'h0, 1'b1, 10'h258});
    wr(IDX_FILTER_CTRL, 8'h07, r);
    for (int c = 0; c < 7; c++) if (c != 3) wr(IDX_FILTER_CTRL, 8'(c), r);
    rd_chk(IDX_FILTER_CTRL, 8'h07, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(IDX_STEP8_LOW, 8'h00, r);
    s_axi_wstrb <= 4'h1;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd_chk(IDX_STEP8_LOW, 8'h5a, RESP_OKAY);
    wr(IDX_MARGIN_MODE, {6'h0, MODE_SOFTWARE}, r);
    wait_clk(3);
    chk({22'h0, margin_offset}, {22'h0, 2'h3, 8'ha5});
    wr(IDX_MARGIN_MODE, {6'h0, MODE_PIN_STEP}, r);
    rd_chk(IDX_MARGIN_MODE, {6'h0, MODE_PIN_STEP}, RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      wait_clk(3);
      chk({22'h0, margin_offset}, {22'h0, STEP_OFS[i]});
      @(posedge clk_sys);
      margin_step_select_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
      margin_step_select_pin <= 1'b0;
    end
    wait_clk(4);
    chk({22'h0, margin_offset}, {22'h0, STEP8_HIGH, 8'h5a});
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CAL_WAIT, {4'h0, c[1:0], c[1:0]}, r);
      wr(IDX_CAL_CONTROL, 8'h01, r);
      #1;
      n = 0;
      while (cal_busy === 1'b1 && n < 64) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(32'(n), 32'(VC[c] + CC[c]));
      chk({27'h0, cal_done, closed_loop_wait_select, vco_settle_wait_select}, {27'h0, 1'b1, c[1:0], c[1:0]});
    end
    rd_chk(IDX_CAL_STATUS, 8'h72, RESP_OKAY);
    stop_test();
  end
endmodule : xo_margin_pll_wait_regs_test
